// >>> shared/mne_pkg.sv
// Package with opcodes, widths, timing and carrier types for the multiply/idle executor
package mne_pkg;
   localparam int MNE_DW = 8;
   localparam int MNE_PCW = 16;
   localparam logic [7:0] MNE_OPC_PRODUCT = 8'hA4;
   localparam logic [7:0] MNE_OPC_IDLE = 8'h00;
   localparam int MNE_PRODUCT_CYCLES = 4;
   localparam int MNE_IDLE_CYCLES = 1;
   localparam int MNE_MUL_CYCLES_MIN = 2;
   localparam int MNE_MUL_CYCLES_MAX = 7;
   localparam logic [7:0] MNE_BYTE_MAX = 8'hFF;
   localparam logic [7:0] MNE_ZERO8 = 8'h00;
   localparam logic [15:0] MNE_ZERO16 = 16'h0000;
   localparam logic [15:0] MNE_PC_STEP = 16'h0001;
   localparam logic [2:0] MNE_CNT_ZERO = 3'h0;
   localparam logic [2:0] MNE_CNT_ONE = 3'h1;

   // Core state as seen by the executor
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] aux;
      logic [15:0] pc;
      logic product_excess_flag;
      logic carry_flag;
   } mne_core_s;

   typedef enum logic [1:0] {
      MNE_ST_IDLE,
      MNE_ST_MUL,
      MNE_ST_NOP
   } mne_state_e;
endpackage : mne_pkg

// >>> design/mne_product_unit.sv
// Unsigned 8x8 product unit with excess detection
`timescale 1ns/1ps
module mne_product_unit
   import mne_pkg::*;
#(
   parameter int DW = MNE_DW
) (
   input wire logic [DW-1:0] a_in,
   input wire logic [DW-1:0] b_in,
   output logic [DW-1:0] lo_out,
   output logic [DW-1:0] hi_out,
   output logic excess_out
);
   // Elaboration guard; the excess test below compares against a byte-wide zero
   if (DW != MNE_DW) begin : g_dw_check
      $error("mne_product_unit: only 8-bit operands are served");
   end

   // Full-width product, split into bytes; operands widened first so no bit is lost
   wire logic [2*DW-1:0] prod_w = {{DW{1'b0}}, a_in} * {{DW{1'b0}}, b_in};
   assign lo_out = prod_w[DW-1:0];
   assign hi_out = prod_w[2*DW-1:DW];
   // High byte nonzero means product above the byte maximum
   assign excess_out = (prod_w[2*DW-1:DW] != MNE_ZERO8);
endmodule : mne_product_unit

// >>> design/mne_exec.sv
// Executor for the product instruction and the idle instruction
// Notes on behaviour
// - Opcode A4h multiplies accumulator by auxiliary register, unsigned, over 4 machine cycles.
// - The product's low byte goes to the accumulator and high byte to the auxiliary register.
// - The excess flag is set when the product exceeds 255 and cleared otherwise.
// - Every multiply clears the carry flag.
// - Opcode 00h is a one-cycle idle that adds one to the program counter.
// - The idle changes nothing but the program counter.
`timescale 1ns/1ps
module mne_exec
   import mne_pkg::*;
#(
   parameter int MUL_CYCLES = MNE_PRODUCT_CYCLES
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic op_valid_in,
   input wire logic [7:0] opcode_in,
   input wire logic load_in,
   input wire mne_core_s load_val_in,
   output mne_core_s core_out,
   output logic busy_out,
   output logic done_out
);
   // Elaboration guard; MUL_CYCLES is held to 2 through 7 so MUL_LAST fits the three-bit cycle counter
   if (MUL_CYCLES < MNE_MUL_CYCLES_MIN || MUL_CYCLES > MNE_MUL_CYCLES_MAX) begin : g_cycles_check
      $error("mne_exec: MUL_CYCLES out of range");
   end

   localparam logic [2:0] MUL_LAST = 3'(MUL_CYCLES - 1);

   mne_state_e state_q, state_d;
   mne_core_s core_q, core_d;
   logic [2:0] cnt_q, cnt_d;
   logic done_q, done_d;
   logic busy_q, busy_d;
   logic [7:0] lo_w, hi_w;
   logic excess_w;

   // Product formed from the committed registers; operands stay stable while busy
   mne_product_unit #(.DW(MNE_DW)) u_prod (
      .a_in(core_q.acc),
      .b_in(core_q.aux),
      .lo_out(lo_w),
      .hi_out(hi_w),
      .excess_out(excess_w)
   );

   // Decode of the two handled opcodes
   wire logic idle_ready_w = (state_q == MNE_ST_IDLE);
   wire logic start_product_w = idle_ready_w && op_valid_in && (opcode_in == MNE_OPC_PRODUCT);
   wire logic start_idle_w = idle_ready_w && op_valid_in && (opcode_in == MNE_OPC_IDLE);
   wire logic mul_last_w = (state_q == MNE_ST_MUL) && (cnt_q == MUL_LAST);

   // Busy follows the next state so the pin comes straight from a flop
   assign busy_d = (state_d == MNE_ST_MUL);

   // Sequencer and commit logic
   always_comb begin
      state_d = state_q;
      core_d = core_q;
      cnt_d = cnt_q;
      done_d = 1'b0;
      unique case (state_q)
         MNE_ST_IDLE: begin
            if (load_in) begin
               core_d = load_val_in;
            end
            if (start_product_w) begin
               state_d = MNE_ST_MUL;
               cnt_d = MNE_CNT_ONE;
            end else if (start_idle_w) begin
               // Single cycle; only the PC moves
               core_d.pc = core_q.pc + MNE_PC_STEP;
               done_d = 1'b1;
            end
         end
         MNE_ST_MUL: begin
            cnt_d = cnt_q + MNE_CNT_ONE;
            if (mul_last_w) begin
               // All five fields in one edge so nothing half-updated is seen
               core_d.acc = lo_w;
               core_d.aux = hi_w;
               core_d.product_excess_flag = excess_w;
               core_d.carry_flag = 1'b0;
               core_d.pc = core_q.pc + MNE_PC_STEP;
               state_d = MNE_ST_IDLE;
               cnt_d = MNE_CNT_ZERO;
               done_d = 1'b1;
            end
         end
         MNE_ST_NOP: begin
            state_d = MNE_ST_IDLE;
         end
      endcase
   end

   // State register; a reset in mid-multiply abandons the operation
   // with nothing committed, since the commit only happens on the last count
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= MNE_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Committed core state; only the final multiply edge, an idle or a preload moves it
   // Operands are read from here, so they cannot change under a running multiply
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         core_q <= '0;
      end else begin
         core_q <= core_d;
      end
   end

   // Machine-cycle counter within the multiply
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= MNE_CNT_ZERO;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Completion pulse, raised on the same edge as each commit
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         done_q <= 1'b0;
      end else begin
         done_q <= done_d;
      end
   end

   // Busy flag, registered so the pin never shows a decode glitch
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= busy_d;
      end
   end

   // Outputs straight from flops
   assign core_out = core_q;
   assign busy_out = busy_q;
   assign done_out = done_q;

   // Assertions; the repetition counts are written for the default four-cycle multiply
   // Busy for three cycles after the take, then the commit cycle
   a_mul_length: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      start_product_w |=> busy_out [*3] ##1 !busy_out && done_out)
      else $error("multiply did not take four cycles");

   // Operands sampled one edge after the take, so a preload on the take edge is honoured
   a_mul_bytes: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      start_product_w |-> ##4
         ({core_out.aux, core_out.acc} ==
         16'($past(core_q.acc, 3)) * 16'($past(core_q.aux, 3))))
      else $error("product bytes wrong");

   // Excess flag against the full-width product of the same operands
   a_excess_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      start_product_w |-> ##4 (core_out.product_excess_flag ==
         (16'($past(core_q.acc, 3)) * 16'($past(core_q.aux, 3)) > 16'(MNE_BYTE_MAX))))
      else $error("excess flag wrong");

   // A zero high byte must leave the flag cleared, whatever it held before
   a_excess_small: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      mul_last_w && (hi_w == MNE_ZERO8) |=> !core_out.product_excess_flag)
      else $error("excess flag not cleared");

   // Carry cleared on every multiply
   a_carry_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      start_product_w |-> ##4 !core_out.carry_flag)
      else $error("carry not cleared by multiply");

   // Idle advances the pc from its old value, even with a preload on the same edge
   a_idle_pc: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      start_idle_w |=> core_out.pc == $past(core_q.pc) + MNE_PC_STEP && done_out && !busy_out)
      else $error("idle did not advance pc by one");

   // A preload on the idle edge is a separate write, so it is left out here
   a_idle_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      start_idle_w && !load_in |=> $stable(core_out.acc) && $stable(core_out.aux)
         && $stable(core_out.product_excess_flag) && $stable(core_out.carry_flag))
      else $error("idle changed a register");

   // Nothing moves before the last multiply cycle
   a_mul_atomic: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      busy_out && !mul_last_w |=> $stable(core_out))
      else $error("partial update during multiply");

   // Codes offered while busy must not end the multiply early
   a_busy_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      busy_out && !mul_last_w |=> busy_out)
      else $error("multiply cut short");

   // The commit edge moves the pc together with the product
   a_commit_pc: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      mul_last_w |=> done_out && !busy_out && core_out.pc == $past(core_q.pc) + MNE_PC_STEP)
      else $error("commit incomplete");

   // Done lasts one cycle unless an idle follows at once
   a_done_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      done_out |=> !done_out || $past(start_idle_w))
      else $error("done stuck high");

   // Product outcomes
   c_mul_excess: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      mul_last_w && excess_w);
   c_mul_small: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      mul_last_w && !excess_w);

   // Sequencing
   c_idle_run: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      start_idle_w ##1 start_idle_w);
   c_mul_then_idle: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      mul_last_w ##1 start_idle_w);
   c_mul_refused: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      busy_out && op_valid_in);
endmodule : mne_exec

// >>> tb/mne_fetch_model.sv
// Fetch and decode stand-in that hands opcodes to the executor
`timescale 1ns/1ps
module mne_fetch_model (
   input wire logic clk_sys_in,
   output logic op_valid_out,
   output logic [7:0] opcode_out
);
   initial begin
      op_valid_out = 1'b0;
      opcode_out = 8'h00;
   end
   // Held to the take edge; a released bus shows the inverse, not a stale value
   task automatic issue(input logic [7:0] opc);
      @(posedge clk_sys_in);
      op_valid_out <= 1'b1;
      opcode_out <= opc;
      @(posedge clk_sys_in);
      op_valid_out <= 1'b0;
      opcode_out <= ~opc;
   endtask : issue
endmodule : mne_fetch_model

// >>> tb/tb_top.sv
// Self-checking bench for the multiply and idle executor
`timescale 1ns/1ps
module tb_top
   import mne_pkg::*;
();
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic op_valid_in;
   logic [7:0] opcode_in;
   logic load_in = 1'b0;
   mne_core_s load_val_in = '0;
   mne_core_s core_out;
   logic busy_out;
   logic done_out;
   int mismatches = 0;
   int comparisons = 0;
   // 20 MHz core clock
   initial begin
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   mne_exec #(.MUL_CYCLES(MNE_PRODUCT_CYCLES)) u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .op_valid_in(op_valid_in), .opcode_in(opcode_in), .load_in(load_in), .load_val_in(load_val_in),
      .core_out(core_out), .busy_out(busy_out), .done_out(done_out));
   mne_fetch_model u_fetch (.clk_sys_in(clk_sys_in), .op_valid_out(op_valid_in), .opcode_out(opcode_in));
   task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // Preload, issue, then time the commit; k counts edges from the take edge
   task automatic exec(input logic [7:0] opc, input mne_core_s pre, input mne_core_s exp, input int cyc);
      int k;
      int nb;
      @(posedge clk_sys_in);
      load_in <= 1'b1;
      load_val_in <= pre;
      @(posedge clk_sys_in);
      load_in <= 1'b0;
      u_fetch.issue(opc);
      k = 1;
      nb = 0;
      #1;
      while (done_out !== 1'b1 && k < 20) begin
         nb += int'(busy_out === 1'b1);
         chk("early state", core_out, pre);
         @(posedge clk_sys_in);
         #1;
         k++;
      end
      chk("no timeout", 34'(k < 20), 34'd1);
      if (k >= 20) begin
         tally_and_finish();
      end
      chk("cycles", 34'(k), 34'(cyc));
      chk("busy", 34'(nb), 34'(cyc - 1));
      chk("core", core_out, exp);
      @(posedge clk_sys_in);
      #1;
      chk("done pulse", 34'(done_out), 34'd0);
   endtask : exec
   // Flags preset opposite to the outcome so a missed update shows
   task automatic product_case(input logic [7:0] a, input logic [7:0] b);
      logic [15:0] p;
      p = 16'(a) * 16'(b);
      exec(MNE_OPC_PRODUCT, mne_core_s'{a, b, 16'h1234, p <= 16'h00FF, 1'b1},
         mne_core_s'{p[7:0], p[15:8], 16'h1235, p > 16'h00FF, 1'b0}, MNE_PRODUCT_CYCLES);
   endtask : product_case
   // Idle must move only the counter, wrapping at the top
   task automatic idle_case(input logic [15:0] pc, input logic f);
      exec(MNE_OPC_IDLE, mne_core_s'{8'h5A, 8'hC3, pc, f, f}, mne_core_s'{8'h5A, 8'hC3, pc + 16'h0001, f, f},
         MNE_IDLE_CYCLES);
   endtask : idle_case
   // An idle offered while busy is dropped; the multiply still commits on time and pc moves once
   task automatic refused_case;
      @(posedge clk_sys_in);
      load_in <= 1'b1;
      load_val_in <= mne_core_s'{8'h03, 8'h05, 16'h0100, 1'b1, 1'b1};
      @(posedge clk_sys_in);
      load_in <= 1'b0;
      u_fetch.issue(MNE_OPC_PRODUCT);
      u_fetch.issue(MNE_OPC_IDLE);
      @(posedge clk_sys_in);
      #1;
      chk("refused done", 34'(done_out), 34'd1);
      chk("refused core", core_out, mne_core_s'{8'h0F, 8'h00, 16'h0101, 1'b0, 1'b0});
      @(posedge clk_sys_in);
      #1;
      chk("refused late", core_out, mne_core_s'{8'h0F, 8'h00, 16'h0101, 1'b0, 1'b0});
      chk("refused pulse", 34'(done_out), 34'd0);
   endtask : refused_case
   // Reset in mid-multiply clears everything at once and nothing commits afterwards
   task automatic reset_mid_case;
      @(posedge clk_sys_in);
      load_in <= 1'b1;
      load_val_in <= mne_core_s'{8'h21, 8'h43, 16'h0200, 1'b0, 1'b1};
      @(posedge clk_sys_in);
      load_in <= 1'b0;
      u_fetch.issue(MNE_OPC_PRODUCT);
      @(posedge clk_sys_in);
      rst_n_in <= 1'b0;
      #1;
      chk("mid reset core", core_out, '0);
      chk("mid reset busy", 34'(busy_out), 34'd0);
      chk("mid reset done", 34'(done_out), 34'd0);
      repeat (2) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      #1;
      chk("after reset core", core_out, '0);
      chk("after reset done", 34'(done_out), 34'd0);
   endtask : reset_mid_case
   initial begin
      repeat (5) @(posedge clk_sys_in);
      chk("reset state", {core_out}, '0);
      chk("reset busy", 34'(busy_out), 34'd0);
      chk("reset done", 34'(done_out), 34'd0);
      rst_n_in <= 1'b1;
      product_case(8'h50, 8'hA0);
      product_case(8'hFF, 8'h01);
      product_case(8'h10, 8'h10);
      product_case(8'hFF, 8'hFF);
      product_case(8'h00, 8'h7F);
      refused_case();
      reset_mid_case();
      idle_case(16'hFFFF, 1'b1);
      idle_case(16'h0010, 1'b0);
      tally_and_finish();
   end
endmodule : tb_top
